// ### hw/caf_pkg.sv
package caf_pkg;

  // ----------------------------------------------------------------
  // filter and buffer geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_FILTERS   = 16;
  localparam int unsigned FILT_IDX_W    = 4;
  localparam int unsigned REG_W         = 16;

  // ----------------------------------------------------------------
  // filter register field positions
  // ----------------------------------------------------------------
  localparam int unsigned SID_MSB       = 15;
  localparam int unsigned SID_LSB       = 5;
  localparam int unsigned IDE_BIT       = 3;
  localparam int unsigned EXT_MSB       = 1;
  localparam int unsigned EXT_LSB       = 0;
  // implemented bits: 15..5, 3, 1..0 (bits 4 and 2 read zero)
  localparam logic [15:0] FILT_IMPL_MASK = 16'hFFEB;

  // ----------------------------------------------------------------
  // data word byte lanes
  // ----------------------------------------------------------------
  localparam int unsigned HI_BYTE_LSB   = 8;
  localparam int unsigned LO_BYTE_LSB   = 0;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] FILT_BASE     = 12'h000; // 16 words, 0x000..0x03c
  localparam logic [11:0] DATA_W4_OFS   = 12'h040;
  localparam logic [11:0] DATA_W5_OFS   = 12'h044;
  localparam logic [11:0] MASK_EN_OFS   = 12'h048; // per-filter type mask enables
  localparam logic [11:0] FILT_EN_OFS   = 12'h04C; // per-filter enables
  localparam logic [11:0] HIT_OFS       = 12'h050; // last compare result
  localparam logic [15:0] MASK_EN_RST   = 16'h0000;
  localparam logic [15:0] FILT_EN_RST   = 16'h0000;

  // ----------------------------------------------------------------
  // ahb-lite constants
  // ----------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0]  HTRANS_SEQ    = 2'b11;

  // received frame identifier under test
  typedef struct packed {
    logic [10:0] std_id;
    logic [1:0]  ext_upper;
    logic        is_ext;
  } caf_rx_id_t;

  // compare result
  typedef struct packed {
    logic        hit;
    logic [3:0]  filter_num;
    logic [15:0] hit_vec;
  } caf_result_t;

endpackage

// ### hw/caf_filter_match.sv
`timescale 1ns/1ps
module caf_filter_match
  import caf_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [11:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // received frame from the bit engine
  input  wire logic        rx_valid_in,
  input  wire caf_rx_id_t  rx_id_in,
  input  wire logic [7:0]  rx_byte2_in,
  input  wire logic [7:0]  rx_byte3_in,
  input  wire logic [7:0]  rx_byte4_in,
  input  wire logic [7:0]  rx_byte5_in,
  // compare result
  output logic             result_valid_out,
  output caf_result_t      result_out
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] filt_q [NUM_FILTERS];  // no reset: content undefined
  logic [15:0] word4_q;               // data bytes 3/2
  logic [15:0] word5_q;               // data bytes 5/4
  logic [15:0] mask_en_q;             // per-filter type mask enable
  logic [15:0] filt_en_q;             // per-filter enable
  // the hit path is combinational from the filter bank to the result register
  logic [15:0] hit_vec;               // combinational per-filter hit
  logic        any_hit;               // some enabled filter hit
  logic [3:0]  hit_num;               // lowest hitting filter

  // ----------------------------------------------------------------
  // ahb-lite address phase capture
  // ----------------------------------------------------------------
  logic        ph_wr_q;    // write data phase pending
  logic        ph_rd_q;    // read data phase pending
  logic [11:0] ph_addr_q;  // captured address
  logic        take;       // valid transfer accepted this cycle

  // only nonseq and seq start a transfer; idle and busy are ignored
  assign take = hsel_in && hready_in && htrans_in[1];

  // zero wait states, always okay
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // capture each accepted transfer for its data phase
  // hsize is not decoded: every register is one whole aligned word
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ph_wr_q   <= 1'b0;
      ph_rd_q   <= 1'b0;
      ph_addr_q <= 12'h000;
    end else if (hready_in) begin
      ph_wr_q   <= take && hwrite_in;
      ph_rd_q   <= take && !hwrite_in;
      ph_addr_q <= haddr_in;
    end
  end

  // decode helpers on the data phase address
  // the bank spans the first sixteen words, so bits 5..2 pick the filter
  logic       filt_sel;   // address falls in filter bank
  logic [3:0] filt_idx;   // filter index from address
  assign filt_sel = (ph_addr_q[11:6] == FILT_BASE[11:6]);
  assign filt_idx = ph_addr_q[5:2];

  // ----------------------------------------------------------------
  // filter bank: one register and one comparator per filter
  // ----------------------------------------------------------------
  // no reset on the filter storage: software must load a pattern first
  // trade-off: sixteen parallel comparators answer within one cycle
  genvar g;
  generate
    for (g = 0; g < NUM_FILTERS; g++) begin : g_filt
      // write path; unimplemented bits forced to zero
      always_ff @(posedge mclk_in) begin
        if (ph_wr_q && filt_sel && filt_idx == 4'(g)) begin
          filt_q[g] <= hwdata_in[15:0] & FILT_IMPL_MASK;
        end
      end

      // compare against the received identifier
      logic sid_ok;  // standard id bits equal
      logic ext_ok;  // extended id 17..16 equal
      logic typ_ok;  // frame type admitted
      assign sid_ok = (filt_q[g][SID_MSB:SID_LSB] == rx_id_in.std_id);
      assign ext_ok = (filt_q[g][EXT_MSB:EXT_LSB] == rx_id_in.ext_upper);
      // type bit only counts when this filter's mask enable is set
      assign typ_ok = !mask_en_q[g] || (filt_q[g][IDE_BIT] == rx_id_in.is_ext);
      // all conditions together; disabled filters never hit
      assign hit_vec[g] = filt_en_q[g] && sid_ok && ext_ok && typ_ok;
    end
  endgenerate

  // lowest numbered hitting filter wins
  // scanning downward lets the lowest index overwrite the higher ones
  always_comb begin
    hit_num = 4'h0;
    for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_num = 4'(i);
      end
    end
  end
  assign any_hit = |hit_vec;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // mask and filter enables reset to off so garbage filters stay quiet
  // writes to any other address leave both enables untouched
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mask_en_q <= MASK_EN_RST;
      filt_en_q <= FILT_EN_RST;
    end else if (ph_wr_q) begin
      if (ph_addr_q == MASK_EN_OFS) begin
        mask_en_q <= hwdata_in[15:0];
      end
      if (ph_addr_q == FILT_EN_OFS) begin
        filt_en_q <= hwdata_in[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // message data words: frame load or software write
  // ----------------------------------------------------------------
  // a received frame that hits overrides a simultaneous software write
  // limitation: a software write in the same cycle as a frame load is lost
  always_ff @(posedge mclk_in) begin
    if (rx_valid_in && any_hit) begin
      word4_q <= {rx_byte3_in, rx_byte2_in};
      word5_q <= {rx_byte5_in, rx_byte4_in};
    end else if (ph_wr_q) begin
      if (ph_addr_q == DATA_W4_OFS) begin
        word4_q <= hwdata_in[15:0];
      end
      if (ph_addr_q == DATA_W5_OFS) begin
        word5_q <= hwdata_in[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // compare result register
  // ----------------------------------------------------------------
  // one-cycle valid pulse per received identifier
  // result_out keeps its value until the next identifier arrives
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      result_valid_out <= 1'b0;
      result_out       <= '0;
    end else begin
      result_valid_out <= rx_valid_in;
      if (rx_valid_in) begin
        result_out.hit        <= any_hit;
        result_out.filter_num <= hit_num;
        result_out.hit_vec    <= hit_vec;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data: combinational in the data phase
  // ----------------------------------------------------------------
  // unmapped offsets read zero and accept writes silently
  // the upper half of every register word except the hit status is always zero
  always_comb begin
    hrdata_out = 32'h0000_0000;
    if (ph_rd_q) begin
      if (filt_sel) begin
        hrdata_out = {16'h0000, filt_q[filt_idx] & FILT_IMPL_MASK};
      end else begin
        case (ph_addr_q)
          DATA_W4_OFS: hrdata_out = {16'h0000, word4_q};
          DATA_W5_OFS: hrdata_out = {16'h0000, word5_q};
          MASK_EN_OFS: hrdata_out = {16'h0000, mask_en_q};
          FILT_EN_OFS: hrdata_out = {16'h0000, filt_en_q};
          HIT_OFS:     hrdata_out = {11'h000, result_out.hit,
                                     result_out.filter_num, result_out.hit_vec};
          default:     hrdata_out = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // all checks sample on the controller clock and stay quiet in reset
  chk_unimpl_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    ph_rd_q && filt_sel |-> hrdata_out[4] == 1'b0 && hrdata_out[2] == 1'b0)
    else $error("unimplemented filter bit read nonzero");

  chk_filter_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    ph_wr_q && filt_sel |=> filt_q[$past(filt_idx)][15:5] == $past(hwdata_in[15:5]))
    else $error("filter write not stored");

  chk_sid_needed: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in && hit_vec[0] |-> filt_q[0][15:5] == rx_id_in.std_id)
    else $error("hit without standard id equality");

  chk_type_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in && mask_en_q[0] && hit_vec[0] |-> filt_q[0][3] == rx_id_in.is_ext)
    else $error("type select ignored under mask enable");

  chk_ext_needed: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in && hit_vec[1] |-> filt_q[1][1:0] == rx_id_in.ext_upper)
    else $error("hit without extended bits equality");

  chk_word4_bytes: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in && any_hit |=> word4_q == {$past(rx_byte3_in), $past(rx_byte2_in)})
    else $error("word 4 byte order wrong");

  chk_word5_bytes: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in && any_hit |=> word5_q == {$past(rx_byte5_in), $past(rx_byte4_in)})
    else $error("word 5 byte order wrong");

  chk_result_hit: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in |=> result_valid_out && result_out.hit == $past(any_hit))
    else $error("result does not follow compare");

  chk_disabled_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in |=> (result_out.hit_vec & ~$past(filt_en_q)) == 16'h0000)
    else $error("disabled filter reported a hit");

  // the reported filter hits and no lower numbered filter does
  chk_hit_lowest: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in && any_hit |-> hit_vec[hit_num] &&
      (hit_vec & ((16'h0001 << hit_num) - 16'h0001)) == 16'h0000)
    else $error("reported filter is not the lowest hit");

  // valid only follows a received identifier, never without one
  chk_result_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
    !rx_valid_in |=> !result_valid_out)
    else $error("result valid without a received identifier");

  // per-filter mask enables take the written value
  chk_mask_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    ph_wr_q && ph_addr_q == MASK_EN_OFS |=> mask_en_q == $past(hwdata_in[15:0]))
    else $error("mask enable write not stored");

  // the two unimplemented bits are never stored
  chk_unimpl_store: assert property (@(posedge mclk_in) disable iff (rst_in)
    ph_wr_q && filt_sel |=>
      filt_q[$past(filt_idx)][4] == 1'b0 && filt_q[$past(filt_idx)][2] == 1'b0)
    else $error("unimplemented filter bit stored");

  // every filter's own verdict is kept in the result
  chk_result_vec: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in |=> result_out.hit_vec == $past(hit_vec))
    else $error("per-filter hit vector not kept");

  // read data is zero outside a read data phase
  chk_read_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
    !ph_rd_q |-> hrdata_out == 32'h0000_0000)
    else $error("read data driven outside a read");

  // the status word shows the held result
  chk_hit_status: assert property (@(posedge mclk_in) disable iff (rst_in)
    ph_rd_q && ph_addr_q == HIT_OFS |-> hrdata_out[20:0] == result_out)
    else $error("hit status read differs from result");

  // a frame that hits nothing leaves the data words alone
  chk_word_keep: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in && !any_hit && !ph_wr_q |=>
      word4_q == $past(word4_q) && word5_q == $past(word5_q))
    else $error("data words changed without a hit or a write");

  cov_hit: cover property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in && any_hit);
  cov_miss: cover property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in && filt_en_q != 16'h0000 && !any_hit);
  cov_multi: cover property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in && $countones(hit_vec) > 1);
  cov_type_gated: cover property (@(posedge mclk_in) disable iff (rst_in)
    rx_valid_in && any_hit && mask_en_q[hit_num]);
  cov_soft_word: cover property (@(posedge mclk_in) disable iff (rst_in)
    ph_wr_q && ph_addr_q == DATA_W4_OFS);

endmodule

// ### tb/caf_rx_node.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// remote node model: one frame per request, prompt or late
// ----------------------------------------------------------------
module caf_rx_node
  import caf_pkg::*;
(
  // clock and request from the bench
  input  wire logic        mclk_in,
  input  wire logic        req_in,
  input  wire logic [1:0]  gap_in,
  input  wire caf_rx_id_t  id_in,
  input  wire logic [31:0] dat_in,
  // frame towards the filter
  output logic             rx_valid_out = 1'b0,
  output caf_rx_id_t       rx_id_out = '0,
  output logic [31:0]      dat_out = 32'h0000_0000
);
  logic [2:0] cnt_q = 3'h0; // cycles left before delivery
  // outside a frame the lines toggle, so a stale value never looks valid
  always_ff @(posedge mclk_in) begin
    cnt_q        <= req_in ? {1'b0, gap_in} + 3'h1 : (cnt_q != 3'h0) ? cnt_q - 3'h1 : 3'h0;
    rx_valid_out <= (cnt_q == 3'h1);
    rx_id_out    <= (cnt_q == 3'h1) ? id_in : ~rx_id_out;
    dat_out      <= (cnt_q == 3'h1) ? dat_in : ~dat_out;
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb
  import caf_pkg::*;
;
  // ----------------------------------------------------------------
  // clock, reset, bus and frame signals
  // ----------------------------------------------------------------
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic        req     = 1'b0;
  logic [11:0] haddr   = 12'h000;
  logic [1:0]  htrans  = 2'b00;
  logic [1:0]  gap     = 2'b00;
  logic [31:0] hwdata  = 32'h0000_0000;
  logic [31:0] fdat    = 32'h0000_0000;
  logic [31:0] hrdata, rd_s, dat, d, q;
  logic        hready, rdy_s, rv, rv_in, hresp, rsp_s;
  caf_rx_id_t  fid = '0;
  caf_rx_id_t  rid, id;
  caf_result_t res;
  // bench shadow of what software has programmed
  logic [15:0] flt [16];
  logic [15:0] en, mk, w4, w5;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          seed        = 32'hfea8;

  initial forever #2.5 mclk_in = ~mclk_in;
  // sample at mid-cycle: equals what the next rising edge sees
  always @(negedge mclk_in) begin
    rd_s  = hrdata;
    rdy_s = hready;
    rsp_s = hresp;
  end

  caf_filter_match u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hready_in(hready),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .rx_valid_in(rv_in), .rx_id_in(rid), .rx_byte2_in(dat[7:0]), .rx_byte3_in(dat[15:8]),
    .rx_byte4_in(dat[23:16]), .rx_byte5_in(dat[31:24]), .result_valid_out(rv),
    .result_out(res));
  caf_rx_node u_node (.mclk_in(mclk_in), .req_in(req), .gap_in(gap), .id_in(fid),
    .dat_in(fdat), .rx_valid_out(rv_in), .rx_id_out(rid), .dat_out(dat));

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // wait for hready under a bound; a hang ends the run
  task automatic hold();
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (rdy_s !== 1'b1 && n < 50);
    if (rdy_s !== 1'b1) begin
      fail_count++;
      $display("mismatch t=%0t bus hang", $time);
      results();
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    hold();
    htrans <= 2'b00;
    hwdata <= wd;
    hold();
    q = rd_s;
    chk({31'h0000_0000, rsp_s}, 32'h0000_0000);
  endtask

  // model of the compare: lowest enabled filter that matches wins
  function automatic caf_result_t expect_res(input caf_rx_id_t i);
    caf_result_t r;
    r = '0;
    for (int n = 15; n >= 0; n--) begin
      r.hit_vec[n] = en[n] && flt[n][15:5] == i.std_id && flt[n][1:0] == i.ext_upper
                     && (!mk[n] || flt[n][3] == i.is_ext);
      if (r.hit_vec[n])
        r.filter_num = 4'(n);
    end
    r.hit = |r.hit_vec;
    return r;
  endfunction

  task automatic frame(input caf_rx_id_t i, input logic [31:0] fd);
    int n;
    caf_result_t e;
    e = expect_res(i);
    fid  <= i;
    fdat <= fd;
    gap  <= 2'($random(seed));
    req  <= 1'b1;
    @(posedge mclk_in);
    req <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (rv !== 1'b1 && n < 20);
    if (rv !== 1'b1) begin
      fail_count++;
      $display("mismatch t=%0t no compare result", $time);
      results();
    end
    chk({11'h000, res}, {11'h000, e});
    @(posedge mclk_in);
    if (e.hit) begin
      w4 = fd[15:0];
      w5 = fd[31:16];
    end
    bus(1'b0, DATA_W4_OFS, 32'h0000_0000);
    chk(q, {16'h0000, w4});
    bus(1'b0, DATA_W5_OFS, 32'h0000_0000);
    chk(q, {16'h0000, w5});
    bus(1'b0, HIT_OFS, 32'h0000_0000);
    chk(q, {11'h000, e});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    bus(1'b0, MASK_EN_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b0, FILT_EN_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // every filter gets a defined pattern before any is enabled
    for (int n = 0; n < 16; n++) begin
      d = $random(seed) | ((n % 2) ? 32'h0000_0014 : 32'h0000_0000);
      flt[n] = d[15:0] & FILT_IMPL_MASK;
      bus(1'b1, FILT_BASE + 12'(4 * n), d);
    end
    for (int n = 0; n < 16; n++) begin
      bus(1'b0, FILT_BASE + 12'(4 * n), 32'h0000_0000);
      chk(q, {16'h0000, flt[n]});
    end
    bus(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    bus(1'b0, 12'h0FC, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    d = $random(seed);
    w4 = d[15:0];
    w5 = d[31:16];
    bus(1'b1, DATA_W4_OFS, d);
    bus(1'b1, DATA_W5_OFS, {16'h0000, w5});
    mk = 16'($random(seed));
    en = 16'($random(seed));
    bus(1'b1, MASK_EN_OFS, {16'h0000, mk});
    bus(1'b1, FILT_EN_OFS, {16'h0000, en});
    // mostly matching ids, every fourth one with an id bit flipped unless d[8:5] is 14 or 15 (shift past the 14-bit id)
    for (int i = 0; i < 48; i++) begin
      if (i == 40) begin
        en = 16'h0000;
        bus(1'b1, FILT_EN_OFS, 32'h0000_0000);
      end
      d = $random(seed);
      id = {flt[d[3:0]][15:5], flt[d[3:0]][1:0], d[4]};
      if (i % 4 == 0)
        id = id ^ (14'h0001 << d[8:5]);
      frame(id, $random(seed));
    end
    // a second reset mid-run clears the enables and the hit status
    rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    bus(1'b0, FILT_EN_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b0, MASK_EN_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b0, HIT_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    results();
  end
endmodule
